/* bench/cdb_proc_model.sv */
// processor-side model: enters debug mode on irq, leaves it on resume
`timescale 1ns/1ps
module cdb_proc_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // entry pulse from the unit, return request from the bench
  input wire logic i_irq,
  input wire logic i_resume,
  output logic o_debug_mode
);
  // mode holds until return, so a hit cannot retrigger meanwhile
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_debug_mode <= 1'b0;
    end else if (i_irq) begin
      o_debug_mode <= 1'b1;
    end else if (i_resume) begin
      o_debug_mode <= 1'b0;
    end
  end
endmodule : cdb_proc_model

/* bench/tb_cdb_debug_unit.sv */
// self-checking bench of the debug and breakpoint unit
`timescale 1ns/1ps
module tb_cdb_debug_unit;
  import cdb_pkg::*;
  // stimulus and observed signals
  logic clk = 1'b0, rst_n = 1'b0, ps_wr = 1'b0, ps_rd = 1'b0, tc_wr = 1'b0, tc_rd = 1'b0;
  logic host = 1'b0, dc = 1'b0, exv = 1'b0, memv = 1'b0, resume = 1'b0;
  logic [7:0] ps_a = 8'h00, dthr = 8'h00, mthr = 8'h00, rthr = 8'h00;
  logic [31:0] ps_wd = 32'h0, tc_wd = 32'h0, saved_program_counter = 32'hA000_0000, saved_stack_pointer = 32'hB000_0000;
  logic [31:0] expc = 32'h0, maddr = 32'h0, rid = 32'h0, ps_q, tc_q;
  logic [2:0] tc_idx = 3'h0, exthr = 3'h0;
  logic [3:0] dwen = 4'h0, dwor = 4'h0, rwhit = 4'h0;
  logic ps_rv, tc_rv, irq, dmode;
  logic [7:0] halt, rsel_t;
  logic [4:0] rsel_r;
  int failures = 0, samples_checked = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  cdb_debug_unit #(.THREADS(8)) dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_ps_wr(ps_wr), .i_ps_rd(ps_rd), .i_ps_addr(ps_a),
    .i_ps_wdata(ps_wd), .o_ps_rdata(ps_q), .o_ps_rvalid(ps_rv), .i_tc_wr(tc_wr),
    .i_tc_rd(tc_rd), .i_tc_idx(tc_idx), .i_tc_wdata(tc_wd), .o_tc_rdata(tc_q),
    .o_tc_rvalid(tc_rv), .i_debug_mode(dmode), .i_host_req(host), .i_debug_call_instr(dc),
    .i_debug_call_instr_thread(dthr), .i_saved_pc(saved_program_counter), .i_saved_sp(saved_stack_pointer), .i_exec_valid(exv),
    .i_exec_thread(exthr), .i_exec_pc(expc), .i_mem_valid(memv), .i_mem_thread(mthr),
    .i_mem_addr(maddr), .i_dw_enable(dwen), .i_dw_cond_or(dwor), .i_rw_hit(rwhit),
    .i_rw_thread(rthr), .i_rw_id(rid), .o_debug_irq(irq), .o_thread_halt(halt),
    .o_regread_thread(rsel_t), .o_regread_reg(rsel_r)
  );
  cdb_proc_model proc (
    .i_clk(clk), .i_reset_n(rst_n), .i_irq(irq), .i_resume(resume), .o_debug_mode(dmode)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] cw(input logic [2:0] c, input logic [1:0] i,
                                     input logic [7:0] t);
    return {14'h0, i, t, 5'h0, c};
  endfunction : cw

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ps_wr <= 1'b1;
    ps_a <= a;
    ps_wd <= d;
    @(posedge clk);
    ps_wr <= 1'b0;
  endtask : wr

  // read answers one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    ps_rd <= 1'b1;
    ps_a <= a;
    @(posedge clk);
    ps_rd <= 1'b0;
    #1;
    chk({31'h0, ps_rv}, 32'h1);
    chk(ps_q, exp);
  endtask : rd

  // triggers are raised by the caller one edge before; cleared here after one cycle
  task automatic enter(input logic fire, input logic [31:0] word, input logic [31:0] dat);
    @(posedge clk);
    {host, dc, exv, memv} <= 4'h0;
    rwhit <= 4'h0;
    #1;
    chk({31'h0, irq}, {31'h0, fire});
    if (fire) begin
      rd(CDB_OFF_CAUSE, word);
      rd(CDB_OFF_DATA, dat);
      rd(CDB_OFF_SAVED_PC, saved_program_counter);
      rd(CDB_OFF_SAVED_SP, saved_stack_pointer);
      chk({24'h0, halt}, 32'h0);
      @(posedge clk);
      resume <= 1'b1;
      @(posedge clk);
      resume <= 1'b0;
      @(posedge clk);
      saved_program_counter <= saved_program_counter + 32'h10;
      saved_stack_pointer <= saved_stack_pointer + 32'h20;
    end
  endtask : enter

  task automatic ex(input logic [2:0] t, input logic [31:0] pc);
    @(posedge clk);
    exv <= 1'b1;
    exthr <= t;
    expc <= pc;
  endtask : ex

  task automatic mem(input logic [31:0] a);
    @(posedge clk);
    memv <= 1'b1;
    mthr <= 8'h02;
    maddr <= a;
  endtask : mem

  task automatic t_reset;
    rd(CDB_OFF_CAUSE, 32'h0);
    for (int k = 0; k < 4; k++) begin
      rd(CDB_OFF_IB_CTRL + 8'(k), 32'h0);
    end
    rd(8'h17, 32'h0);
    chk({24'h0, halt}, 32'h0);
  endtask : t_reset

  task automatic t_selects;
    wr(CDB_OFF_THR_SEL, 32'hFFFF_FFFF);
    rd(CDB_OFF_THR_SEL, 32'h0000_00FF);
    wr(CDB_OFF_REG_SEL, 32'hFFFF_FFFF);
    rd(CDB_OFF_REG_SEL, 32'h0000_001F);
    chk({24'h0, rsel_t}, 32'hFF);
    chk({27'h0, rsel_r}, 32'h1F);
  endtask : t_selects

  task automatic t_ibreak;
    wr(CDB_OFF_IB_ADDR + 8'h01, 32'h0000_4000);
    wr(CDB_OFF_IB_CTRL + 8'h01, 32'hFF08_FFFD);
    rd(CDB_OFF_IB_CTRL + 8'h01, 32'h0008_0001);
    ex(3'h2, 32'h0000_4000);
    enter(1'b0, 32'h0, 32'h0);
    ex(3'h3, 32'h0000_4000);
    enter(1'b1, cw(3'h3, 2'h1, 8'h03), 32'h0);
    wr(CDB_OFF_IB_ADDR, 32'h0000_4000);
    wr(CDB_OFF_IB_CTRL, 32'h0008_0001);
    ex(3'h3, 32'h0000_4000);
    enter(1'b1, cw(3'h3, 2'h0, 8'h03), 32'h0);
    wr(CDB_OFF_IB_CTRL, 32'h0008_0003);
    ex(3'h3, 32'h0000_4000);
    enter(1'b1, cw(3'h3, 2'h1, 8'h03), 32'h0);
    ex(3'h3, 32'h0000_4004);
    enter(1'b1, cw(3'h3, 2'h0, 8'h03), 32'h0);
  endtask : t_ibreak

  task automatic t_calls;
    @(posedge clk);
    host <= 1'b1;
    dc <= 1'b1;
    dthr <= 8'h06;
    enter(1'b1, cw(3'h1, 2'h0, 8'h00), 32'h0);
    @(posedge clk);
    dc <= 1'b1;
    enter(1'b1, cw(3'h2, 2'h0, 8'h06), 32'h0);
  endtask : t_calls

  task automatic t_watch;
    wr(CDB_OFF_DW_ADDR1 + 8'h02, 32'h0000_8000);
    wr(CDB_OFF_DW_ADDR2 + 8'h02, 32'h0000_8010);
    rd(CDB_OFF_DW_ADDR1 + 8'h02, 32'h0000_8000);
    rd(CDB_OFF_DW_ADDR2 + 8'h02, 32'h0000_8010);
    @(posedge clk);
    dwen <= 4'h4;
    mem(32'h0000_8000);
    enter(1'b0, 32'h0, 32'h0);
    @(posedge clk);
    dwor <= 4'h4;
    mem(32'h0000_8010);
    enter(1'b1, cw(3'h4, 2'h2, 8'h02), 32'h0000_8010);
    @(posedge clk);
    rwhit <= 4'hA;
    rthr <= 8'h05;
    rid <= 32'h0000_0ABC;
    enter(1'b1, cw(3'h5, 2'h1, 8'h05), 32'h0000_0ABC);
  endtask : t_watch

  task automatic t_stop;
    wr(CDB_OFF_STOP, 32'hFFFF_FF05);
    rd(CDB_OFF_STOP, 32'h0000_0005);
    chk({24'h0, halt}, 32'h05);
    @(posedge clk);
    host <= 1'b1;
    enter(1'b1, cw(3'h1, 2'h0, 8'h00), 32'h0000_0ABC);
    // halt is relaunched on the edge enter returns at; let it settle
    #1;
    chk({24'h0, halt}, 32'h05);
  endtask : t_stop

  // both ports reach the same eight words
  task automatic t_scratch;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      tc_wr <= 1'b1;
      tc_idx <= 3'(k);
      tc_wd <= 32'h5C00_0000 | 32'(k);
      @(posedge clk);
      tc_wr <= 1'b0;
      rd(CDB_OFF_SCRATCH + 8'(k), 32'h5C00_0000 | 32'(k));
    end
    // debug-port write, then tile-side read of that word right behind it
    @(posedge clk);
    ps_wr <= 1'b1;
    ps_a <= CDB_OFF_SCRATCH + 8'h07;
    ps_wd <= 32'hC0DE_0007;
    tc_idx <= 3'h7;
    @(posedge clk);
    ps_wr <= 1'b0;
    tc_rd <= 1'b1;
    @(posedge clk);
    tc_rd <= 1'b0;
    #1;
    chk({31'h0, tc_rv}, 32'h1);
    chk(tc_q, 32'hC0DE_0007);
  endtask : t_scratch

  task automatic final_report;
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_selects();
    t_ibreak();
    t_calls();
    t_watch();
    t_stop();
    t_scratch();
    final_report();
  end

  // a hang counts as a failure; the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule : tb_cdb_debug_unit

/* hdl/cdb_debug_unit.sv */
// debug entry snapshot, stop mask, scratch words and breakpoint unit
//
// Contract
// - on debug entry capture saved program counter into readable writable word
// - on debug entry capture saved stack pointer into readable writable word
// - 8-bit thread select for register-read instruction, upper bits read zero
// - 5-bit register select for register-read instruction, upper bits read zero
// - cause code 1 host, 2 call, 3 ibreak, 4 dwatch, 5 rwatch; resets 0
// - breakpoint index field, zero for host and call entries
// - simultaneous hits report the lowest-numbered breakpoint
// - thread field holds causing thread, zero for host entries
// - data watch hit loads the access effective address into data word
// - resource watch hit loads the resource identifier into data word
// - stop mask keeps marked threads halted after debug return
// - outside debug mode marked threads do not run, others run
// - eight scratch words shared between debug port and tile config port
// - enabled instruction breakpoint compares its address with executing pc
// - four independent instruction breakpoints with address and control
// - per-thread enable field in each control word, resets zero
// - condition bit selects equal (0) or not equal (1), resets zero
// - control bit zero enables the breakpoint, resets zero
// - four first data watch addresses in consecutive words
// - four second data watch addresses in consecutive words
// - data watch combines both address matches by AND (0) or OR (1)
`timescale 1ns/1ps
module cdb_debug_unit #(
  parameter int THREADS = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // processor-status register port
  input wire logic i_ps_wr,
  input wire logic i_ps_rd,
  input wire logic [7:0] i_ps_addr,
  input wire logic [31:0] i_ps_wdata,
  output logic [31:0] o_ps_rdata,
  output logic o_ps_rvalid,
  // tile configuration scratch port
  input wire logic i_tc_wr,
  input wire logic i_tc_rd,
  input wire logic [2:0] i_tc_idx,
  input wire logic [31:0] i_tc_wdata,
  output logic [31:0] o_tc_rdata,
  output logic o_tc_rvalid,
  // entry sources and saved context
  input wire logic i_debug_mode,
  input wire logic i_host_req,
  input wire logic i_debug_call_instr,
  input wire logic [7:0] i_debug_call_instr_thread,
  input wire logic [31:0] i_saved_pc,
  input wire logic [31:0] i_saved_sp,
  // executing instruction
  input wire logic i_exec_valid,
  input wire logic [2:0] i_exec_thread,
  input wire logic [31:0] i_exec_pc,
  // memory access and data watch setup
  input wire logic i_mem_valid,
  input wire logic [7:0] i_mem_thread,
  input wire logic [31:0] i_mem_addr,
  input wire logic [3:0] i_dw_enable,
  input wire logic [3:0] i_dw_cond_or,
  // resource watch hit from outside
  input wire logic [3:0] i_rw_hit,
  input wire logic [7:0] i_rw_thread,
  input wire logic [31:0] i_rw_id,
  // to the processor
  output logic o_debug_irq,
  output logic [7:0] o_thread_halt,
  output logic [7:0] o_regread_thread,
  output logic [4:0] o_regread_reg
);
  import cdb_pkg::*;

  if (THREADS < 1 || THREADS > 8) begin : g_chk
    $error("THREADS must be 1 to 8");
  end

  localparam logic [7:0] THR_MASK = 8'((1 << THREADS) - 1);

  // register state
  logic [31:0] saved_pc;
  logic [31:0] saved_sp;
  logic [7:0] thr_sel;
  logic [4:0] reg_sel;
  logic [2:0] cause;
  logic [1:0] bidx;
  logic [7:0] ethr;
  logic [31:0] edata;
  logic [7:0] stop_mask;
  logic [31:0] scratch [8];
  logic [31:0] ib_addr [4];
  logic [7:0] ib_thr [4];
  logic [3:0] ib_ne;
  logic [3:0] ib_en;
  logic [31:0] dw_a1 [4];
  logic [31:0] dw_a2 [4];

  // address decode
  wire wr = i_ps_wr;
  wire [1:0] wi = i_ps_addr[1:0];
  wire hit_scr = i_ps_addr[7:3] == CDB_OFF_SCRATCH[7:3];
  wire hit_iba = i_ps_addr[7:2] == CDB_OFF_IB_ADDR[7:2];
  wire hit_ibc = i_ps_addr[7:2] == CDB_OFF_IB_CTRL[7:2];
  wire hit_dw1 = i_ps_addr[7:2] == CDB_OFF_DW_ADDR1[7:2];
  wire hit_dw2 = i_ps_addr[7:2] == CDB_OFF_DW_ADDR2[7:2];

  // breakpoint and watchpoint hits, one slice per index
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  for (genvar g = 0; g < 4; g++) begin : g_brk
    wire pc_eq = i_exec_pc == ib_addr[g];
    wire thr_ok = ib_thr[g][i_exec_thread];
    // equal or unequal compare per condition bit
    assign ib_hit[g] = i_exec_valid && ib_en[g] && thr_ok && (pc_eq ^ ib_ne[g]);
    wire a_eq = i_mem_addr == dw_a1[g];
    wire b_eq = i_mem_addr == dw_a2[g];
    wire cond = i_dw_cond_or[g] ? (a_eq | b_eq) : (a_eq & b_eq);
    assign dw_hit[g] = i_mem_valid && i_dw_enable[g] && cond;
  end

  // lowest set bit wins
  function automatic logic [1:0] lowest(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (v[k]) begin
        r = 2'(k);
      end
    end
    return r;
  endfunction : lowest

  // entry source priority: host, call, ibreak, dwatch, rwatch
  wire any_ib = |ib_hit;
  wire any_dw = |dw_hit;
  wire any_rw = |i_rw_hit;
  wire trig = !i_debug_mode && (i_host_req || i_debug_call_instr || any_ib || any_dw || any_rw);
  cdb_entry_t nxt;
  assign nxt.cause = i_host_req ? CDB_CAUSE_HOST :
                     i_debug_call_instr ? CDB_CAUSE_DEBUG_CALL_INSTR :
                     any_ib ? CDB_CAUSE_IBREAK :
                     any_dw ? CDB_CAUSE_DWATCH : CDB_CAUSE_RWATCH;
  assign nxt.index = (i_host_req || i_debug_call_instr) ? 2'h0 :
                     any_ib ? lowest(ib_hit) :
                     any_dw ? lowest(dw_hit) : lowest(i_rw_hit);
  assign nxt.thread = i_host_req ? CDB_RST_BYTE :
                      i_debug_call_instr ? i_debug_call_instr_thread :
                      any_ib ? {5'h00, i_exec_thread} :
                      any_dw ? i_mem_thread : i_rw_thread;
  assign nxt.data = any_dw ? i_mem_addr : i_rw_id;
  wire data_load = trig && !i_host_req && !i_debug_call_instr && !any_ib;

  // entry capture wins over a software write in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      saved_pc <= CDB_RST_WORD;
      saved_sp <= CDB_RST_WORD;
      cause <= CDB_CAUSE_NONE;
      bidx <= 2'h0;
      ethr <= CDB_RST_BYTE;
      edata <= CDB_RST_WORD;
    end else if (trig) begin
      saved_pc <= i_saved_pc;
      saved_sp <= i_saved_sp;
      cause <= nxt.cause;
      bidx <= nxt.index;
      ethr <= nxt.thread;
      if (data_load) begin
        edata <= nxt.data;
      end
    end else if (wr) begin
      if (i_ps_addr == CDB_OFF_SAVED_PC) saved_pc <= i_ps_wdata;
      if (i_ps_addr == CDB_OFF_SAVED_SP) saved_sp <= i_ps_wdata;
      if (i_ps_addr == CDB_OFF_DATA) edata <= i_ps_wdata;
      if (i_ps_addr == CDB_OFF_CAUSE) begin
        cause <= i_ps_wdata[CDB_CAUSE_LSB +: 3];
        ethr <= i_ps_wdata[CDB_THREAD_LSB +: 8];
        bidx <= i_ps_wdata[CDB_INDEX_LSB +: 2];
      end
    end
  end

  // operand, stop mask and breakpoint setup writes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      thr_sel <= CDB_RST_BYTE;
      reg_sel <= 5'h00;
      stop_mask <= CDB_RST_BYTE;
      ib_ne <= 4'h0;
      ib_en <= 4'h0;
      for (int k = 0; k < 4; k++) begin
        ib_addr[k] <= CDB_RST_WORD;
        ib_thr[k] <= CDB_RST_BYTE;
        dw_a1[k] <= CDB_RST_WORD;
        dw_a2[k] <= CDB_RST_WORD;
      end
    end else if (wr) begin
      if (i_ps_addr == CDB_OFF_THR_SEL) thr_sel <= i_ps_wdata[7:0];
      if (i_ps_addr == CDB_OFF_REG_SEL) reg_sel <= i_ps_wdata[4:0];
      if (i_ps_addr == CDB_OFF_STOP) stop_mask <= i_ps_wdata[7:0] & THR_MASK;
      if (hit_iba) ib_addr[wi] <= i_ps_wdata;
      if (hit_dw1) dw_a1[wi] <= i_ps_wdata;
      if (hit_dw2) dw_a2[wi] <= i_ps_wdata;
      if (hit_ibc) begin
        ib_thr[wi] <= i_ps_wdata[CDB_IBC_THR_LSB +: 8] & THR_MASK;
        ib_ne[wi] <= i_ps_wdata[CDB_IBC_NE_BIT];
        ib_en[wi] <= i_ps_wdata[CDB_IBC_EN_BIT];
      end
    end
  end

  // shared scratch: debug port wins a same-cycle clash on one word
  wire ps_scr_wr = wr && hit_scr;
  wire tc_clash = ps_scr_wr && (i_ps_addr[2:0] == i_tc_idx);
  always_ff @(posedge i_clk) begin
    if (ps_scr_wr) scratch[i_ps_addr[2:0]] <= i_ps_wdata;
    if (i_tc_wr && !tc_clash) scratch[i_tc_idx] <= i_tc_wdata;
  end

  // read mux, unmapped indices read zero
  wire [31:0] ib_ctl_rd = {8'h00, ib_thr[wi], 14'h0000, ib_ne[wi], ib_en[wi]};
  wire [31:0] cause_rd = {14'h0000, bidx, ethr, 5'h00, cause};
  wire [31:0] rd_word =
    (i_ps_addr == CDB_OFF_SAVED_PC) ? saved_pc :
    (i_ps_addr == CDB_OFF_SAVED_SP) ? saved_sp :
    (i_ps_addr == CDB_OFF_THR_SEL) ? {24'h000000, thr_sel} :
    (i_ps_addr == CDB_OFF_REG_SEL) ? {27'h0000000, reg_sel} :
    (i_ps_addr == CDB_OFF_CAUSE) ? cause_rd :
    (i_ps_addr == CDB_OFF_DATA) ? edata :
    (i_ps_addr == CDB_OFF_STOP) ? {24'h000000, stop_mask} :
    hit_scr ? scratch[i_ps_addr[2:0]] :
    hit_iba ? ib_addr[wi] :
    hit_ibc ? ib_ctl_rd :
    hit_dw1 ? dw_a1[wi] :
    hit_dw2 ? dw_a2[wi] : CDB_RST_WORD;

  // registered read answers, one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ps_rdata <= CDB_RST_WORD;
      o_ps_rvalid <= 1'b0;
      o_tc_rdata <= CDB_RST_WORD;
      o_tc_rvalid <= 1'b0;
    end else begin
      o_ps_rvalid <= i_ps_rd;
      o_tc_rvalid <= i_tc_rd;
      if (i_ps_rd) o_ps_rdata <= rd_word;
      if (i_tc_rd) o_tc_rdata <= scratch[i_tc_idx];
    end
  end

  // processor side outputs; halt released only while in debug mode
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_debug_irq <= 1'b0;
      o_thread_halt <= CDB_RST_BYTE;
      o_regread_thread <= CDB_RST_BYTE;
      o_regread_reg <= 5'h00;
    end else begin
      o_debug_irq <= trig;
      o_thread_halt <= i_debug_mode ? CDB_RST_BYTE : stop_mask;
      o_regread_thread <= thr_sel;
      o_regread_reg <= reg_sel;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_pc_capture;
    trig |=> saved_pc == $past(i_saved_pc) && saved_sp == $past(i_saved_sp);
  endproperty
  a_pc_capture: assert property (p_pc_capture) else $error("pc or sp not captured");

  property p_snapshot;
    trig |=> cause == $past(nxt.cause) && ethr == $past(nxt.thread) && o_debug_irq;
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("entry snapshot torn");

  property p_host_zero;
    (trig && i_host_req) |=> cause == CDB_CAUSE_HOST && ethr == 8'h00 && bidx == 2'h0;
  endproperty
  a_host_zero: assert property (p_host_zero) else $error("host entry fields wrong");

  property p_lowest;
    (trig && !i_host_req && !i_debug_call_instr && ib_hit[0]) |=> bidx == 2'h0;
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest index not reported");

  property p_dw_data;
    (trig && nxt.cause == CDB_CAUSE_DWATCH) |=> edata == $past(i_mem_addr);
  endproperty
  a_dw_data: assert property (p_dw_data) else $error("watch address not loaded");

  property p_halt;
    !i_debug_mode ##1 !i_debug_mode |-> o_thread_halt == $past(stop_mask);
  endproperty
  a_halt: assert property (p_halt) else $error("stop mask not applied");

  property p_run_in_debug;
    i_debug_mode |=> o_thread_halt == 8'h00;
  endproperty
  a_run_in_debug: assert property (p_run_in_debug) else $error("halt held in debug");

  property p_no_entry_in_debug;
    i_debug_mode |=> !o_debug_irq;
  endproperty
  a_no_entry_in_debug: assert property (p_no_entry_in_debug) else $error("entry in debug");

  property p_ib_disabled;
    (ib_en == 4'h0 && !i_host_req && !i_debug_call_instr && !any_dw && !any_rw) |=> !o_debug_irq;
  endproperty
  a_ib_disabled: assert property (p_ib_disabled) else $error("disabled breakpoint fired");

  // a debug-port write must be visible to a tile-side read one cycle later
  property p_scratch_share;
    (i_ps_wr && hit_scr) ##1 (i_tc_rd && i_tc_idx == $past(i_ps_addr[2:0]))
      |=> o_tc_rdata == $past(i_ps_wdata, 2);
  endproperty
  a_scratch_share: assert property (p_scratch_share) else $error("scratch not shared");

  property p_rw_data;
    (trig && nxt.cause == CDB_CAUSE_RWATCH) |=> edata == $past(i_rw_id);
  endproperty
  a_rw_data: assert property (p_rw_data) else $error("resource id not loaded");

  property p_call_fields;
    (trig && !i_host_req && i_debug_call_instr) |=> cause == CDB_CAUSE_DEBUG_CALL_INSTR && bidx == 2'h0 &&
      ethr == $past(i_debug_call_instr_thread);
  endproperty
  a_call_fields: assert property (p_call_fields) else $error("call entry fields wrong");

  property p_reset_vals;
    $rose(i_reset_n) |-> cause == CDB_CAUSE_NONE && ib_en == 4'h0 && ib_ne == 4'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  // the reported breakpoint must be armed for the executing thread
  property p_ib_enabled;
    (trig && nxt.cause == CDB_CAUSE_IBREAK) |->
      ib_en[nxt.index] && ib_thr[nxt.index][i_exec_thread];
  endproperty
  a_ib_enabled: assert property (p_ib_enabled) else $error("ib not armed");

  property p_ib_cond;
    (trig && nxt.cause == CDB_CAUSE_IBREAK) |->
      (i_exec_pc == ib_addr[nxt.index]) != ib_ne[nxt.index];
  endproperty
  a_ib_cond: assert property (p_ib_cond) else $error("ib condition wrong");

  // OR needs one address match, AND needs both
  property p_dw_cond;
    (trig && nxt.cause == CDB_CAUSE_DWATCH) |-> i_dw_enable[nxt.index] &&
      ((i_mem_addr == dw_a1[nxt.index]) + (i_mem_addr == dw_a2[nxt.index]) >
       (i_dw_cond_or[nxt.index] ? 0 : 1));
  endproperty
  a_dw_cond: assert property (p_dw_cond) else $error("watch condition wrong");

  property p_ib_lowest;
    (trig && nxt.cause == CDB_CAUSE_IBREAK) |-> (ib_hit & ((4'h1 << nxt.index) - 4'h1)) == 4'h0;
  endproperty
  a_ib_lowest: assert property (p_ib_lowest) else $error("lower ib hit skipped");

  property p_rw_lowest;
    (trig && nxt.cause == CDB_CAUSE_RWATCH) |-> i_rw_hit[nxt.index] &&
      (i_rw_hit & ((4'h1 << nxt.index) - 4'h1)) == 4'h0;
  endproperty
  a_rw_lowest: assert property (p_rw_lowest) else $error("lower rw hit skipped");

  property p_regread;
    i_reset_n |=> o_regread_thread == $past(thr_sel) && o_regread_reg == $past(reg_sel);
  endproperty
  a_regread: assert property (p_regread) else $error("select copy wrong");

  property p_thr_sel_rsvd;
    (i_ps_rd && i_ps_addr == CDB_OFF_THR_SEL) |=> o_ps_rdata[31:8] == 24'h000000;
  endproperty
  a_thr_sel_rsvd: assert property (p_thr_sel_rsvd) else $error("thread select rsvd");

  property p_reg_sel_rsvd;
    (i_ps_rd && i_ps_addr == CDB_OFF_REG_SEL) |=> o_ps_rdata[31:5] == 27'h0000000;
  endproperty
  a_reg_sel_rsvd: assert property (p_reg_sel_rsvd) else $error("register select rsvd");

  property p_stop_write;
    (i_ps_wr && i_ps_addr == CDB_OFF_STOP) |=>
      stop_mask == ($past(i_ps_wdata[7:0]) & THR_MASK);
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("stop mask write lost");

endmodule : cdb_debug_unit

/* hdl/cdb_pkg.sv */
// constants, offsets and carrier types of the debug and breakpoint unit
package cdb_pkg;

  // register indices on the processor-status port
  localparam logic [7:0] CDB_OFF_SAVED_PC = 8'h11;
  localparam logic [7:0] CDB_OFF_SAVED_SP = 8'h12;
  localparam logic [7:0] CDB_OFF_THR_SEL = 8'h13;
  localparam logic [7:0] CDB_OFF_REG_SEL = 8'h14;
  localparam logic [7:0] CDB_OFF_CAUSE = 8'h15;
  localparam logic [7:0] CDB_OFF_DATA = 8'h16;
  localparam logic [7:0] CDB_OFF_STOP = 8'h18;
  localparam logic [7:0] CDB_OFF_SCRATCH = 8'h20;
  localparam logic [7:0] CDB_OFF_IB_ADDR = 8'h30;
  localparam logic [7:0] CDB_OFF_IB_CTRL = 8'h40;
  localparam logic [7:0] CDB_OFF_DW_ADDR1 = 8'h50;
  localparam logic [7:0] CDB_OFF_DW_ADDR2 = 8'h60;

  // field positions
  localparam int CDB_THR_SEL_W = 8;
  localparam int CDB_REG_SEL_W = 5;
  localparam int CDB_CAUSE_LSB = 0;
  localparam int CDB_THREAD_LSB = 8;
  localparam int CDB_INDEX_LSB = 16;
  localparam int CDB_IBC_EN_BIT = 0;
  localparam int CDB_IBC_NE_BIT = 1;
  localparam int CDB_IBC_THR_LSB = 16;

  // entry cause codes
  localparam logic [2:0] CDB_CAUSE_NONE = 3'h0;
  localparam logic [2:0] CDB_CAUSE_HOST = 3'h1;
  localparam logic [2:0] CDB_CAUSE_DEBUG_CALL_INSTR = 3'h2;
  localparam logic [2:0] CDB_CAUSE_IBREAK = 3'h3;
  localparam logic [2:0] CDB_CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CDB_CAUSE_RWATCH = 3'h5;

  // reset values
  localparam logic [31:0] CDB_RST_WORD = 32'h0000_0000;
  localparam logic [7:0] CDB_RST_BYTE = 8'h00;

  // snapshot written on debug entry
  typedef struct packed {
    logic [2:0] cause;
    logic [1:0] index;
    logic [7:0] thread;
    logic [31:0] data;
  } cdb_entry_t;

endpackage : cdb_pkg
